// file: common/bkpt_trigger_defines.vh
/*
 * Register numbers, field positions and reset values of the trigger block.
 * Assumes inclusion by bare name.
 */
// What this block does
// R1: Level enable adds byte 2 to data compare.
// R2: Level enable adds byte 3 to data compare.
// R3: Data invert bit inverts the combined result of the enabled byte lane comparators.
// R4: Three address mode enables per level; all clear disables it.
// R5: Outside-range enable: true only outside low..high.
// R6: Inside-range enable: address true within inclusive low..high range.
// R7: Exact-low enable: address true when address equals low bound.
// R8: PC breakpoint takes part only when its enable bit is one.
// R9: PC invert set: true outside masked region; clear: true inside it.
// R10: Compare PC with match value, skipping masked bits.
// R11: PC match value holds instruction address in bits 31 down to 1.
// R12: PC mask bit zero compares that bit; one ignores it.
// R13: PC mask at register 0x09, written by supervisor and host writes.
// R14: PC match value: supervisor write, host read and host write.
// R15: Address bounds compared against every local bus transfer address.
// R16: High bound at 0x0C; supervisor write, host read and write.
// R17: Low bound at 0x0D; supervisor write and host write only.
// R18: Low bound is full 32-bit range floor and exact address value.
// R19: High bound is full 32-bit inclusive range ceiling.
// R20: Response field: 00 report only, 01 halt, 10 debug interrupt, 11 reserved.
// R21: Select 0: PC AND address AND data; select 1: PC OR (address AND data).
// R22: Level global enable; clear disables that level.
// R23: PC bit 0 not compared; each transfer judged in the cycle presented.
`ifndef BKPT_TRIGGER_DEFINES_VH
`define BKPT_TRIGGER_DEFINES_VH

// Debug control register numbers
`define REG_TRIGGER_DEFINITION 4'h7
`define REG_PC_MATCH_VALUE 4'h8
`define REG_PC_MATCH_MASK 4'h9
`define REG_ADDR_BOUND_HIGH 4'hC
`define REG_ADDR_BOUND_LOW 4'hD

// Reset values
`define RST_TRIGGER_DEFINITION 32'h0000_0000
`define RST_PC_MATCH_VALUE 32'h0000_0000
`define RST_PC_MATCH_MASK 32'h0000_0000
`define RST_ADDR_BOUND 32'h0000_0000

// Trigger definition fields
`define TRC_HI 31
`define TRC_LO 30
`define LVL2_HI 29
`define LVL2_LO 16
`define LVL1_HI 13
`define LVL1_LO 0
`define LVL2_OR_BIT 15
`define LVL1_OR_BIT 14

// Response encodings
`define RESP_REPORT 2'h0
`define RESP_HALT 2'h1
`define RESP_DBG_INT 2'h2

// Fields in one 14-bit level slice
`define F_EBL 13
`define F_EDLW 12
`define F_EDWL 11
`define F_EDWU 10
`define F_EDLL 9
`define F_EDLM 8
`define F_DATA_BYTE2_ENABLE 7
`define F_DATA_BYTE3_ENABLE 6
`define F_DI 5
`define F_EAI 4
`define F_EAR 3
`define F_EAL 2
`define F_EPC 1
`define F_PCI 0

// Compared PC bits
`define PC_CMP_BITS 32'hFFFF_FFFE

`endif

// file: core/trig_level_eval.v
/*
 * One trigger level: PC, address and data results to one hit.
 * Assumes results of one cycle.
 */
`timescale 1ns/1ps
`include "bkpt_trigger_defines.vh"

module trig_level_eval (
    // Level configuration
    input wire [13:0] cfg,
    input wire or_sel,
    // Raw comparator results
    input wire pc_valid,
    input wire pc_hit,
    input wire bus_valid,
    input wire addr_eq_low,
    input wire addr_in_range,
    input wire [3:0] lane_eq,
    // Result
    output wire hit
);

    wire [3:0] lane_en;
    wire data_en, data_raw, data_cond;
    wire addr_en, addr_raw, addr_cond, bus_part_en;
    wire pc_en, pc_cond, and_hit, or_hit;

    ////////////////////////////////////////////////////////////////////////
    // R1 byte two lane
    // Lanes enabled by longword, word or byte selects
    assign lane_en[0] = cfg[`F_EDLL] | cfg[`F_EDWL] | cfg[`F_EDLW];
    assign lane_en[1] = cfg[`F_EDLM] | cfg[`F_EDWL] | cfg[`F_EDLW];
    assign lane_en[2] = cfg[`F_DATA_BYTE2_ENABLE] | cfg[`F_EDWU] | cfg[`F_EDLW];
    // R2 byte three lane
    assign lane_en[3] = cfg[`F_DATA_BYTE3_ENABLE] | cfg[`F_EDWU] | cfg[`F_EDLW];

    // R3 data invert sense
    // No lane enabled means the data term drops out
    assign data_en = |lane_en;
    assign data_raw = &(lane_eq | ~lane_en);
    assign data_cond = data_en ? (bus_valid & (data_raw ^ cfg[`F_DI])) : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // R4 address mode enables
    assign addr_en = cfg[`F_EAI] | cfg[`F_EAR] | cfg[`F_EAL];
    // R5 R6 R7 address modes
    assign addr_raw = (cfg[`F_EAL] & addr_eq_low) | (cfg[`F_EAR] & addr_in_range)
                    | (cfg[`F_EAI] & ~addr_in_range);
    assign addr_cond = addr_en ? (bus_valid & addr_raw) : 1'b1;
    assign bus_part_en = addr_en | data_en;

    ////////////////////////////////////////////////////////////////////////
    // R8 PC enable gate
    assign pc_en = cfg[`F_EPC];
    // R9 PC invert region
    assign pc_cond = pc_valid & (pc_hit ^ cfg[`F_PCI]);

    // R21 AND or OR form
    assign and_hit = (pc_en | bus_part_en) & (~pc_en | pc_cond) & addr_cond & data_cond;
    assign or_hit = (pc_en & pc_cond) | (bus_part_en & addr_cond & data_cond);

    // R22 level global enable
    assign hit = cfg[`F_EBL] & (or_sel ? or_hit : and_hit);

endmodule // trig_level_eval

// file: core/bkpt_trigger_compare.v
/*
 * Breakpoint trigger comparator.
 * Holds trigger, PC and address registers,
 * compares PC and bus every cycle
 * and raises the chosen response.
 * Assumes every port runs on clk_sys;
 * data match settings come from outside.
 */
`timescale 1ns/1ps
`include "bkpt_trigger_defines.vh"

module bkpt_trigger_compare (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,

    // Supervisor debug write instruction port
    input wire supervisor_debug_write_op,
    input wire [3:0] sup_reg_num,
    input wire [31:0] sup_wr_data,

    // Background debug port register commands
    input wire host_debug_reg_write,
    input wire host_debug_reg_read,
    input wire [3:0] host_reg_num,
    input wire [31:0] host_wr_data,
    output reg host_rd_ack_reg,
    output reg host_rd_err_reg,
    output reg [31:0] host_rd_data_reg,

    // Core program counter
    input wire pc_valid,
    input wire [31:0] pc_value,

    // Core local bus transfer
    input wire bus_valid,
    input wire [31:0] bus_addr,
    input wire [31:0] bus_data,

    // Data match settings from the data register block
    input wire [31:0] data_match_value,
    input wire [31:0] data_match_mask,

    // Trigger responses
    output reg [1:0] debug_data_outputs_reg,
    output reg trig_report_reg,
    output reg halt_req_reg,
    output reg dbg_int_req_reg,
    output reg level2_armed_reg
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    reg [31:0] trigger_definition_reg;
    reg [31:0] pc_match_value_reg;
    reg [31:0] pc_match_mask_reg;
    reg [31:0] addr_bound_high_reg;
    reg [31:0] addr_bound_low_reg;

    // Next-state signals
    reg [31:0] trigger_definition_next;
    reg [31:0] pc_match_value_next;
    reg [31:0] pc_match_mask_next;
    reg [31:0] addr_bound_high_next;
    reg [31:0] addr_bound_low_next;
    reg [31:0] rd_data_next;
    reg rd_err_next;

    // Comparator results
    wire pc_hit;
    wire addr_eq_low;
    wire addr_in_range;
    wire [3:0] lane_eq;
    wire [1:0] level_hit;
    wire [1:0] level_en;
    wire [1:0] or_sel;
    wire [1:0] resp_sel;
    wire tdr_written;
    wire complete;

    ////////////////////////////////////////////////////////////////////////
    // Register write decode
    // Supervisor write last, so it wins a tie
    always @* begin
        trigger_definition_next = trigger_definition_reg;
        pc_match_value_next = pc_match_value_reg;
        pc_match_mask_next = pc_match_mask_reg;
        addr_bound_high_next = addr_bound_high_reg;
        addr_bound_low_next = addr_bound_low_reg;
        if (host_debug_reg_write) begin
            case (host_reg_num)
                `REG_TRIGGER_DEFINITION: begin
                    trigger_definition_next = host_wr_data;
                end
                // R14 host write of match value
                `REG_PC_MATCH_VALUE: begin
                    pc_match_value_next = host_wr_data;
                end
                // R13 host write of mask
                `REG_PC_MATCH_MASK: begin
                    pc_match_mask_next = host_wr_data;
                end
                // R16 host write of high bound
                `REG_ADDR_BOUND_HIGH: begin
                    addr_bound_high_next = host_wr_data;
                end
                // R17 host write of low bound
                `REG_ADDR_BOUND_LOW: begin
                    addr_bound_low_next = host_wr_data;
                end
                default: begin
                    trigger_definition_next = trigger_definition_reg;
                end
            endcase
        end
        if (supervisor_debug_write_op) begin
            case (sup_reg_num)
                `REG_TRIGGER_DEFINITION: begin
                    trigger_definition_next = sup_wr_data;
                end
                // R14 supervisor write of match value
                `REG_PC_MATCH_VALUE: begin
                    pc_match_value_next = sup_wr_data;
                end
                // R13 supervisor write of mask
                `REG_PC_MATCH_MASK: begin
                    pc_match_mask_next = sup_wr_data;
                end
                // R16 supervisor write of high bound
                `REG_ADDR_BOUND_HIGH: begin
                    addr_bound_high_next = sup_wr_data;
                end
                // R17 supervisor write of low bound
                `REG_ADDR_BOUND_LOW: begin
                    addr_bound_low_next = sup_wr_data;
                end
                default: begin
                    trigger_definition_next = trigger_definition_next;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host read decode
    // Write-only or unmapped: zero data and error
    always @* begin
        rd_data_next = 32'h0000_0000;
        rd_err_next = 1'b0;
        case (host_reg_num)
            `REG_TRIGGER_DEFINITION: begin
                rd_data_next = trigger_definition_reg;
            end
            // R14 host read of match value
            `REG_PC_MATCH_VALUE: begin
                rd_data_next = pc_match_value_reg;
            end
            // R16 host read of high bound
            `REG_ADDR_BOUND_HIGH: begin
                rd_data_next = addr_bound_high_reg;
            end
            // R17 low bound not readable
            `REG_ADDR_BOUND_LOW: begin
                rd_err_next = 1'b1;
            end
            `REG_PC_MATCH_MASK: begin
                rd_err_next = 1'b1;
            end
            default: begin
                rd_err_next = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register update and host read answer
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            trigger_definition_reg <= `RST_TRIGGER_DEFINITION;
            pc_match_value_reg <= `RST_PC_MATCH_VALUE;
            pc_match_mask_reg <= `RST_PC_MATCH_MASK;
            addr_bound_high_reg <= `RST_ADDR_BOUND;
            addr_bound_low_reg <= `RST_ADDR_BOUND;
            host_rd_ack_reg <= 1'b0;
            host_rd_err_reg <= 1'b0;
            host_rd_data_reg <= 32'h0000_0000;
        end else begin
            trigger_definition_reg <= trigger_definition_next;
            pc_match_value_reg <= pc_match_value_next;
            pc_match_mask_reg <= pc_match_mask_next;
            // R19 full 32-bit high bound
            addr_bound_high_reg <= addr_bound_high_next;
            // R18 full 32-bit low bound
            addr_bound_low_reg <= addr_bound_low_next;
            host_rd_ack_reg <= host_debug_reg_read;
            host_rd_err_reg <= host_debug_reg_read & rd_err_next;
            if (host_debug_reg_read) begin
                host_rd_data_reg <= rd_data_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PC comparator
    // R10 masked PC compare
    // R11 R12 R23 bits 31..1 only, mask one ignores bit
    assign pc_hit = ((pc_value ^ pc_match_value_reg) & ~pc_match_mask_reg
                    & `PC_CMP_BITS) == 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Address comparators
    // R15 every bus transfer address
    assign addr_eq_low = (bus_addr == addr_bound_low_reg);
    // R6 inclusive range
    assign addr_in_range = (bus_addr >= addr_bound_low_reg)
                         & (bus_addr <= addr_bound_high_reg);

    ////////////////////////////////////////////////////////////////////////
    // Data compare per byte lane, masked per bit
    genvar gl;
    generate
        for (gl = 0; gl < 4; gl = gl + 1) begin : g_lane
            assign lane_eq[gl] = ((bus_data[gl*8 +: 8] ^ data_match_value[gl*8 +: 8])
                                 & ~data_match_mask[gl*8 +: 8]) == 8'h00;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Level 1 low half, level 2 high half
    assign or_sel[0] = trigger_definition_reg[`LVL1_OR_BIT];
    assign or_sel[1] = trigger_definition_reg[`LVL2_OR_BIT];
    assign level_en[0] = trigger_definition_reg[`LVL1_LO + `F_EBL];
    assign level_en[1] = trigger_definition_reg[`LVL2_LO + `F_EBL];

    trig_level_eval u_level1 (
        .cfg(trigger_definition_reg[`LVL1_HI:`LVL1_LO]),
        .or_sel(or_sel[0]),
        .pc_valid(pc_valid),
        .pc_hit(pc_hit),
        .bus_valid(bus_valid),
        .addr_eq_low(addr_eq_low),
        .addr_in_range(addr_in_range),
        .lane_eq(lane_eq),
        .hit(level_hit[0])
    );

    trig_level_eval u_level2 (
        .cfg(trigger_definition_reg[`LVL2_HI:`LVL2_LO]),
        .or_sel(or_sel[1]),
        .pc_valid(pc_valid),
        .pc_hit(pc_hit),
        .bus_valid(bus_valid),
        .addr_eq_low(addr_eq_low),
        .addr_in_range(addr_in_range),
        .lane_eq(lane_eq),
        .hit(level_hit[1])
    );

    ////////////////////////////////////////////////////////////////////////
    // Trigger sequencing
    // Both levels on: level 1 arms, level 2 completes.
    // One level on: that level completes alone.
    assign tdr_written = (host_debug_reg_write & (host_reg_num == `REG_TRIGGER_DEFINITION))
                       | (supervisor_debug_write_op
                          & (sup_reg_num == `REG_TRIGGER_DEFINITION));

    // R22 levels gated by global enables
    assign complete = (level_en == 2'b01) ? level_hit[0] :
                      (level_en == 2'b10) ? level_hit[1] :
                      (level_en == 2'b11) ? (level2_armed_reg & level_hit[1]) : 1'b0;

    assign resp_sel = trigger_definition_reg[`TRC_HI:`TRC_LO];

    // Arm state, cleared by completion, definition write or either level off
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            level2_armed_reg <= 1'b0;
        end else if (tdr_written || level_en != 2'b11) begin
            level2_armed_reg <= 1'b0;
        end else if (complete) begin
            level2_armed_reg <= 1'b0;
        end else if (level_hit[0]) begin
            level2_armed_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response pulses, one cycle after completion
    // R20 response select
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            trig_report_reg <= 1'b0;
            halt_req_reg <= 1'b0;
            dbg_int_req_reg <= 1'b0;
            debug_data_outputs_reg <= 2'h0;
        end else begin
            trig_report_reg <= complete;
            halt_req_reg <= complete & (resp_sel == `RESP_HALT);
            dbg_int_req_reg <= complete & (resp_sel == `RESP_DBG_INT);
            if (complete) begin
                debug_data_outputs_reg <= resp_sel; // Response always shown
            end else begin
                debug_data_outputs_reg <= 2'h0;
            end
        end
    end

endmodule // bkpt_trigger_compare

// file: tb/bkpt_trigger_checker.sv
/* Checks read answers and responses.
   Sees only the design's ports. */
`timescale 1ns/1ps
module bkpt_trigger_checker (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Register access
    input wire supervisor_debug_write_op,
    input wire host_debug_reg_write,
    input wire host_debug_reg_read,
    input wire [3:0] host_reg_num,
    input wire [31:0] host_wr_data,
    input wire host_rd_ack_reg,
    input wire host_rd_err_reg,
    input wire [31:0] host_rd_data_reg,
    // Core side and responses
    input wire pc_valid,
    input wire bus_valid,
    input wire [1:0] debug_data_outputs_reg,
    input wire trig_report_reg,
    input wire halt_req_reg,
    input wire dbg_int_req_reg
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // High bound write, then read back
    sequence s_rd(n);
        host_debug_reg_read && host_reg_num == n;
    endsequence
    sequence s_wr_high;
        host_debug_reg_write && host_reg_num == 4'hC && !supervisor_debug_write_op;
    endsequence
    sequence s_quiet;
        !host_debug_reg_write && !supervisor_debug_write_op;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    property p_rd_ack; host_debug_reg_read |=> host_rd_ack_reg; endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
    property p_ack_cause; host_rd_ack_reg |-> $past(host_debug_reg_read); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without read");
    property p_wo_err;
        host_debug_reg_read && (host_reg_num == 4'h9 || host_reg_num == 4'hD)
        |=> host_rd_err_reg && host_rd_data_reg == 32'h0;
    endproperty
    a_wo_err: assert property (p_wo_err) else $error("write-only read");
    property p_rw_ok;
        host_debug_reg_read && (host_reg_num == 4'h8 || host_reg_num == 4'hC)
        |=> host_rd_ack_reg && !host_rd_err_reg;
    endproperty
    a_rw_ok: assert property (p_rw_ok) else $error("readable reg refused");
    property p_high_back;
        s_wr_high ##1 s_quiet ##1 s_rd(4'hC) |=> host_rd_data_reg == $past(host_wr_data, 3);
    endproperty
    a_high_back: assert property (p_high_back) else $error("high bound readback");
    property p_halt;
        halt_req_reg |-> trig_report_reg && debug_data_outputs_reg == 2'h1 && !dbg_int_req_reg;
    endproperty
    a_halt: assert property (p_halt) else $error("halt response");
    property p_int;
        dbg_int_req_reg |-> trig_report_reg && debug_data_outputs_reg == 2'h2 && !halt_req_reg;
    endproperty
    a_int: assert property (p_int) else $error("interrupt response");
    property p_quiet_out;
        !trig_report_reg |-> debug_data_outputs_reg == 2'h0 && !halt_req_reg && !dbg_int_req_reg;
    endproperty
    a_quiet_out: assert property (p_quiet_out) else $error("response without report");
    property p_idle; !pc_valid && !bus_valid |=> !trig_report_reg; endproperty
    a_idle: assert property (p_idle) else $error("trigger with no input");
endmodule // bkpt_trigger_checker

bind bkpt_trigger_compare bkpt_trigger_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .supervisor_debug_write_op(supervisor_debug_write_op),
    .host_debug_reg_write(host_debug_reg_write), .host_debug_reg_read(host_debug_reg_read),
    .host_reg_num(host_reg_num), .host_wr_data(host_wr_data),
    .host_rd_ack_reg(host_rd_ack_reg), .host_rd_err_reg(host_rd_err_reg),
    .host_rd_data_reg(host_rd_data_reg), .pc_valid(pc_valid), .bus_valid(bus_valid),
    .debug_data_outputs_reg(debug_data_outputs_reg), .trig_report_reg(trig_report_reg),
    .halt_req_reg(halt_req_reg), .dbg_int_req_reg(dbg_int_req_reg));

// file: tb/core_bus_model.sv
/* Core model: one PC and/or bus transfer per call.
   Assumes calls start on a falling edge. */
`timescale 1ns/1ps
module core_bus_model (
    // Clock
    input wire clk_sys,
    // Program counter and bus transfer
    output logic pc_valid,
    output logic [31:0] pc_value,
    output logic bus_valid,
    output logic [31:0] bus_addr,
    output logic [31:0] bus_data
);
    // Idle at time zero
    initial begin
        pc_valid = 1'b0;
        bus_valid = 1'b0;
        pc_value = 32'h0;
        bus_addr = 32'h0;
        bus_data = 32'h0;
    end
    // One cycle of traffic, then inverted stale values
    task automatic step(input logic pv, input logic [31:0] pc, input logic bv,
        input logic [31:0] a, input logic [31:0] d);
        pc_valid = pv;
        pc_value = pc;
        bus_valid = bv;
        bus_addr = a;
        bus_data = d;
        @(negedge clk_sys);
        pc_valid = 1'b0;
        bus_valid = 1'b0;
        pc_value = ~pc;
        bus_addr = ~a;
        bus_data = ~d;
    endtask
endmodule // core_bus_model

// file: tb/tb_bkpt_trigger_compare.sv
/* Bench: register access, then trigger responses.
   Assumes falling-edge stimulus. */
`timescale 1ns/1ps
`include "bkpt_trigger_defines.vh"
module tb_bkpt_trigger_compare;
    localparam logic [4:0] T_NO = 5'h00;
    localparam logic [4:0] T_REP = 5'h10;
    localparam logic [4:0] T_HALT = 5'h19;
    localparam logic [4:0] T_INT = 5'h16;
    localparam logic [4:0] T_RSV = 5'h13;
    logic clk_sys = 1'b0, rst_n = 1'b0;
    logic supervisor_debug_write_op = 1'b0, host_debug_reg_write = 1'b0, host_debug_reg_read = 1'b0;
    logic [3:0] sup_reg_num = 4'h0, host_reg_num = 4'h0;
    logic [31:0] sup_wr_data = 32'h0, host_wr_data = 32'h0;
    logic [31:0] data_match_value = 32'h0, data_match_mask = 32'h0;
    logic host_rd_ack_reg, host_rd_err_reg, pc_valid, bus_valid;
    logic [31:0] host_rd_data_reg, pc_value, bus_addr, bus_data;
    logic [1:0] debug_data_outputs_reg;
    logic trig_report_reg, halt_req_reg, dbg_int_req_reg, level2_armed_reg;
    logic [31:0] adr [4] = '{32'h0000_00FF, 32'h0000_0100, 32'h0000_01FF, 32'h0000_0200};
    logic [3:0] exp_a [3] = '{4'b0010, 4'b0110, 4'b1001};
    int n_mismatch = 0, n_tests = 0, cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock, design and core model
    always #2 clk_sys = ~clk_sys;
    bkpt_trigger_compare dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .supervisor_debug_write_op(supervisor_debug_write_op), .sup_reg_num(sup_reg_num),
        .sup_wr_data(sup_wr_data), .host_debug_reg_write(host_debug_reg_write),
        .host_debug_reg_read(host_debug_reg_read), .host_reg_num(host_reg_num),
        .host_wr_data(host_wr_data), .host_rd_ack_reg(host_rd_ack_reg),
        .host_rd_err_reg(host_rd_err_reg), .host_rd_data_reg(host_rd_data_reg),
        .pc_valid(pc_valid), .pc_value(pc_value), .bus_valid(bus_valid),
        .bus_addr(bus_addr), .bus_data(bus_data), .data_match_value(data_match_value),
        .data_match_mask(data_match_mask), .debug_data_outputs_reg(debug_data_outputs_reg),
        .trig_report_reg(trig_report_reg), .halt_req_reg(halt_req_reg),
        .dbg_int_req_reg(dbg_int_req_reg), .level2_armed_reg(level2_armed_reg));
    core_bus_model core (.clk_sys(clk_sys), .pc_valid(pc_valid), .pc_value(pc_value),
        .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data));
    ////////////////////////////////////////////////////////////////////////
    // Compare tasks
    task automatic chk_rd(input logic [33:0] e, input logic [33:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t read exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_trig(input logic [4:0] e, input logic [4:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t trigger exp=%h got=%h", $time, e, g);
        end
    endtask
    // Write on either port
    task automatic wr(input logic sup, input logic [3:0] n, input logic [31:0] d);
        if (sup) begin
            supervisor_debug_write_op = 1'b1;
            sup_reg_num = n;
            sup_wr_data = d;
        end else begin
            host_debug_reg_write = 1'b1;
            host_reg_num = n;
            host_wr_data = d;
        end
        @(negedge clk_sys);
        supervisor_debug_write_op = 1'b0;
        host_debug_reg_write = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic cfg(input logic [31:0] d);
        wr(1'b1, `REG_TRIGGER_DEFINITION, d);
    endtask
    // Host read, answer one edge later
    task automatic rd(input logic [3:0] n, input logic e_err, input logic [31:0] e_d);
        host_debug_reg_read = 1'b1;
        host_reg_num = n;
        @(negedge clk_sys);
        host_debug_reg_read = 1'b0;
        chk_rd({1'b1, e_err, e_d}, {host_rd_ack_reg, host_rd_err_reg, host_rd_data_reg});
        @(negedge clk_sys);
    endtask
    // One core cycle, then its response
    task automatic hit(input logic pv, input logic [31:0] pc, input logic bv,
        input logic [31:0] a, input logic [31:0] d, input logic [4:0] e);
        core.step(pv, pc, bv, a, d);
        chk_trig(e, {trig_report_reg, halt_req_reg, dbg_int_req_reg,
            debug_data_outputs_reg});
        @(negedge clk_sys);
    endtask
    task automatic pcx(input logic [31:0] pc, input logic [4:0] e);
        hit(1'b1, pc, 1'b0, 32'h0, 32'h0, e);
    endtask
    task automatic bx(input logic [31:0] a, input logic [31:0] d, input logic [4:0] e);
        hit(1'b0, 32'h0, 1'b1, a, d, e);
    endtask
    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        rd(`REG_TRIGGER_DEFINITION, 1'b0, 32'h0);
        rd(`REG_PC_MATCH_VALUE, 1'b0, 32'h0);
        rd(`REG_PC_MATCH_MASK, 1'b1, 32'h0);
        rd(`REG_ADDR_BOUND_LOW, 1'b1, 32'h0);
        rd(4'h3, 1'b1, 32'h0);
        wr(1'b0, `REG_ADDR_BOUND_HIGH, 32'hFFFF_FFFF);
        rd(`REG_ADDR_BOUND_HIGH, 1'b0, 32'hFFFF_FFFF);
        wr(1'b1, `REG_ADDR_BOUND_HIGH, 32'h0000_01FF);
        rd(`REG_ADDR_BOUND_HIGH, 1'b0, 32'h0000_01FF);
        wr(1'b0, `REG_PC_MATCH_VALUE, 32'h0000_1000);
        rd(`REG_PC_MATCH_VALUE, 1'b0, 32'h0000_1000);
        wr(1'b0, `REG_ADDR_BOUND_LOW, 32'h0000_0100);
        wr(1'b1, `REG_PC_MATCH_MASK, 32'h0000_00F0);
        end_test("access");
        cfg(32'h4000_2002);
        pcx(32'h0000_1000, T_HALT);
        pcx(32'h0000_1011, T_HALT);
        pcx(32'h0000_1100, T_NO);
        cfg(32'h4000_2003);
        pcx(32'h0000_1100, T_HALT);
        pcx(32'h0000_1000, T_NO);
        cfg(32'h4000_0002);
        pcx(32'h0000_1000, T_NO);
        cfg(32'h4000_2000);
        pcx(32'h0000_1000, T_NO);
        cfg(32'hC000_2002);
        pcx(32'h0000_1000, T_RSV);
        end_test("pc");
        for (int m = 0; m < 3; m++) begin
            cfg(32'h0000_2000 | (32'h0000_0004 << m));
            for (int k = 0; k < 4; k++) begin
                bx(adr[k], 32'h0, exp_a[m][k] ? T_REP : T_NO);
            end
        end
        end_test("address");
        data_match_value = 32'h11AB_2233;
        cfg(32'h8000_2080);
        bx(32'h0, 32'hFFAB_0000, T_INT);
        bx(32'h0, 32'h11AA_2233, T_NO);
        data_match_mask = 32'h0001_0000;
        bx(32'h0, 32'h11AA_2233, T_INT);
        data_match_mask = 32'h0000_0000;
        cfg(32'h8000_2040);
        bx(32'h0, 32'h1100_0000, T_INT);
        bx(32'h0, 32'h10AB_2233, T_NO);
        cfg(32'h8000_20A0);
        bx(32'h0, 32'h11AC_2233, T_INT);
        bx(32'h0, 32'h00AB_0000, T_NO);
        end_test("data");
        cfg(32'h4000_2006);
        pcx(32'h0000_1000, T_NO);
        hit(1'b1, 32'h0000_1000, 1'b1, 32'h0000_0100, 32'h0, T_HALT);
        cfg(32'h4000_6006);
        pcx(32'h0000_1000, T_HALT);
        cfg(32'h6004_2002);
        pcx(32'h0000_1000, T_NO);
        chk_trig(5'h01, {4'h0, level2_armed_reg});
        bx(32'h0000_0100, 32'h0, T_HALT);
        end_test("levels");
        complete_run();
    end
endmodule // tb_bkpt_trigger_compare
